// ==== rtl/rotate_consts.svh ====
// Constants for the rotate datapath: opcodes, bit positions, reset values.
// Assumes an 8-bit data path and a single 50 MHz clock domain.
//
// Summary of operation
// - Left rotate into accumulator, memory untouched, flags kept
// - Left rotate through carry, written back
// - Left rotate through carry into accumulator
// - Through-carry accumulator form keeps memory, other flags
// - Right rotate in place, bit 0 to 7
`ifndef ROTATE_CONSTS_SVH
`define ROTATE_CONSTS_SVH

`define ROT_DATA_W     8
`define ROT_MSB        7
`define ROT_LSB        0
`define ROT_OP_W       2
`define ROT_OP_RLA     2'h0
`define ROT_OP_RLC     2'h1
`define ROT_OP_ROTATE_LEFT_WITH_CARRY_TO_ACC    2'h2
`define ROT_OP_RR      2'h3
`define ROT_BYTE_RST   8'h00
`define ROT_FLAG_RST   1'h0
`define ROT_LATENCY    1

`endif

// ==== rtl/rotate_pkg.sv ====
// Types shared by the rotate datapath files.
// Assumes rotate_consts.svh is on the include path.
`include "rotate_consts.svh"

package rotate_pkg;

    // Rotate operations handled by this block
    typedef enum logic [`ROT_OP_W-1:0] {
        rotate_left_to_acc            = `ROT_OP_RLA,
        rotate_left_with_carry        = `ROT_OP_RLC,
        rotate_left_with_carry_to_acc = `ROT_OP_ROTATE_LEFT_WITH_CARRY_TO_ACC,
        rotate_right_in_place         = `ROT_OP_RR
    } rot_op_t;

    // One request: operation, memory operand, incoming carry
    typedef struct packed {
        rot_op_t                  op;
        logic [`ROT_DATA_W-1:0]   operand;
        logic                     carry_in;
    } rot_req_t;

    // One result: value and where it goes, plus carry update
    typedef struct packed {
        logic [`ROT_DATA_W-1:0]   value;
        logic                     to_mem;
        logic                     to_acc;
        logic                     carry_wr;
        logic                     carry_out;
    } rot_res_t;

endpackage

// ==== rtl/rotate_unit.sv ====
// Combinational rotate core: one request in, one steered result out.
// Assumes the caller registers the result; no state is held here.
`timescale 1ns/1ps

module rotate_unit
    import rotate_pkg::*;
(
    input  wire rot_req_t req,   // Operation and operands
    output rot_res_t      res    // Rotated value and destinations
);

    // Decode and rotate in one pass
    always_comb begin
        res = '0;
        unique case (req.op)
            rotate_left_to_acc: begin
                // Bit 7 wraps to bit 0, result only to accumulator
                res.value  = {req.operand[`ROT_MSB-1:`ROT_LSB], req.operand[`ROT_MSB]};
                res.to_acc = 1'b1;
            end
            rotate_left_with_carry: begin
                // Old carry enters bit 0, old bit 7 leaves as carry
                res.value     = {req.operand[`ROT_MSB-1:`ROT_LSB], req.carry_in};
                res.to_mem    = 1'b1;
                res.carry_wr  = 1'b1;
                res.carry_out = req.operand[`ROT_MSB];
            end
            rotate_left_with_carry_to_acc: begin
                // Same shift as above but steered to accumulator only
                res.value     = {req.operand[`ROT_MSB-1:`ROT_LSB], req.carry_in};
                res.to_acc    = 1'b1;
                res.carry_wr  = 1'b1;
                res.carry_out = req.operand[`ROT_MSB];
            end
            rotate_right_in_place: begin
                // Bit 0 wraps to bit 7, written back, no flag touched
                res.value  = {req.operand[`ROT_LSB], req.operand[`ROT_MSB:`ROT_LSB+1]};
                res.to_mem = 1'b1;
            end
        endcase
    end

endmodule

// ==== rtl/rotate_datapath.sv ====
// Top of the rotate datapath: takes a request strobe, returns registered
// result, write strobes for memory and accumulator, and the carry flag.
// Assumes decode supplies the operand and current carry on the same clock.
`timescale 1ns/1ps
`include "rotate_consts.svh"

module rotate_datapath
    import rotate_pkg::*;
(
    input  wire logic                   ref_clk,    // 50 MHz core clock
    input  wire logic                   rst,        // Async reset, active high
    input  wire logic                   req_valid,  // One-cycle request strobe
    input  wire rot_req_t               req,        // Request fields
    output logic [`ROT_DATA_W-1:0]      result_reg, // Rotated byte
    output logic                        mem_we_reg, // Write result to memory
    output logic                        acc_we_reg, // Write result to accumulator
    output logic                        carry_reg,  // Carry flag as held here
    output logic                        done_reg    // Result valid pulse
);

    rot_res_t res;        // Combinational result of the core
    logic     carry_next; // Carry for the next cycle

    // Pure rotate core
    rotate_unit u_core (
        .req (req),
        .res (res)
    );

    // Carry only moves for through-carry forms; otherwise carry_reg holds its own value
    always_comb begin
        carry_next = carry_reg;
        if (req_valid && res.carry_wr) begin
            carry_next = res.carry_out;
        end
    end

    // Result and write strobes; strobes last one cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_reg <= `ROT_BYTE_RST;
            mem_we_reg <= 1'b0;
            acc_we_reg <= 1'b0;
            done_reg   <= 1'b0;
        end else begin
            result_reg <= req_valid ? res.value : result_reg;
            mem_we_reg <= req_valid & res.to_mem;
            acc_we_reg <= req_valid & res.to_acc;
            done_reg   <= req_valid;
        end
    end

    // Carry flag holder; untouched by plain rotates
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            carry_reg <= `ROT_FLAG_RST;
        end else begin
            carry_reg <= carry_next;
        end
    end

    // Accumulator forms never write memory
    property p_acc_no_mem;
        @(posedge ref_clk) disable iff (rst)
        req_valid && (req.op == rotate_left_to_acc || req.op == rotate_left_with_carry_to_acc)
        |=> acc_we_reg && !mem_we_reg;
    endproperty
    a_acc_no_mem: assert property (p_acc_no_mem) else $error("acc rotate wrote memory");

    // Left to accumulator value
    property p_rla;
        @(posedge ref_clk) disable iff (rst)
        req_valid && req.op == rotate_left_to_acc
        |=> result_reg == {$past(req.operand[6:0]), $past(req.operand[7])};
    endproperty
    a_rla: assert property (p_rla) else $error("left rotate value wrong");

    // Through-carry in place: value, carry, memory write
    property p_rlc;
        @(posedge ref_clk) disable iff (rst)
        req_valid && req.op == rotate_left_with_carry
        |=> mem_we_reg && result_reg == {$past(req.operand[6:0]), $past(req.carry_in)}
            && carry_reg == $past(req.operand[7]);
    endproperty
    a_rlc: assert property (p_rlc) else $error("carry rotate wrong");

    // Through-carry to accumulator
    property p_rotate_left_with_carry_to_acc;
        @(posedge ref_clk) disable iff (rst)
        req_valid && req.op == rotate_left_with_carry_to_acc
        |=> result_reg == {$past(req.operand[6:0]), $past(req.carry_in)}
            && carry_reg == $past(req.operand[7]);
    endproperty
    a_rotate_left_with_carry_to_acc: assert property (p_rotate_left_with_carry_to_acc) else $error("carry acc rotate wrong");

    // Right rotate in place
    property p_rr;
        @(posedge ref_clk) disable iff (rst)
        req_valid && req.op == rotate_right_in_place
        |=> mem_we_reg && !acc_we_reg
            && result_reg == {$past(req.operand[0]), $past(req.operand[7:1])};
    endproperty
    a_rr: assert property (p_rr) else $error("right rotate wrong");

    // Plain rotates keep carry
    property p_flag_keep;
        @(posedge ref_clk) disable iff (rst)
        req_valid && (req.op == rotate_right_in_place || req.op == rotate_left_to_acc)
        |=> $stable(carry_reg);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("carry moved");

    // Strobes are single cycle when requests stop
    property p_strobe_pulse;
        @(posedge ref_clk) disable iff (rst)
        req_valid ##1 !req_valid |=> !mem_we_reg && !acc_we_reg && !done_reg;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe held");

    // Exactly one destination per request
    property p_one_dest;
        @(posedge ref_clk) disable iff (rst)
        done_reg |-> (mem_we_reg ^ acc_we_reg);
    endproperty
    a_one_dest: assert property (p_one_dest) else $error("destination wrong");

    // Request shapes, one per operation, so the step-wise checks below read
    // as "this request, then that answer" rather than repeating the decode.
    sequence s_rla_req;
        req_valid && req.op == rotate_left_to_acc;
    endsequence

    sequence s_rlc_req;
        req_valid && req.op == rotate_left_with_carry;
    endsequence

    sequence s_rotate_left_with_carry_to_acc_req;
        req_valid && req.op == rotate_left_with_carry_to_acc;
    endsequence

    sequence s_rr_req;
        req_valid && req.op == rotate_right_in_place;
    endsequence

    // Idle cycle: nothing taken at this edge
    sequence s_idle;
        !req_valid;
    endsequence

    // Every taken request answers exactly one cycle later
    property p_done_follows;
        @(posedge ref_clk) disable iff (rst)
        req_valid |=> done_reg;
    endproperty
    a_done_follows: assert property (p_done_follows) else $error("done missing");

    // No request, no strobes: memory and accumulator stay untouched
    property p_idle_quiet;
        @(posedge ref_clk) disable iff (rst)
        s_idle |=> !done_reg && !mem_we_reg && !acc_we_reg;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe without request");

    // Result byte holds while no request is taken
    property p_result_hold;
        @(posedge ref_clk) disable iff (rst)
        s_idle |=> $stable(result_reg);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved while idle");

    // Carry holds while no request is taken
    property p_carry_idle;
        @(posedge ref_clk) disable iff (rst)
        s_idle |=> $stable(carry_reg);
    endproperty
    a_carry_idle: assert property (p_carry_idle) else $error("carry moved while idle");

    // Left rotate into accumulator: accumulator strobe only, carry kept
    property p_rla_dest;
        @(posedge ref_clk) disable iff (rst)
        s_rla_req |=> acc_we_reg && !mem_we_reg && $stable(carry_reg);
    endproperty
    a_rla_dest: assert property (p_rla_dest) else $error("left rotate dest wrong");

    // Through-carry in place goes to memory, never the accumulator
    property p_rlc_dest;
        @(posedge ref_clk) disable iff (rst)
        s_rlc_req |=> mem_we_reg && !acc_we_reg;
    endproperty
    a_rlc_dest: assert property (p_rlc_dest) else $error("carry rotate dest wrong");

    // Through-carry to accumulator: accumulator strobe, memory kept
    property p_rotate_left_with_carry_to_acc_dest;
        @(posedge ref_clk) disable iff (rst)
        s_rotate_left_with_carry_to_acc_req |=> acc_we_reg && !mem_we_reg;
    endproperty
    a_rotate_left_with_carry_to_acc_dest: assert property (p_rotate_left_with_carry_to_acc_dest) else $error("carry acc dest wrong");

    // Plain right rotate leaves carry exactly as it was
    property p_rr_carry;
        @(posedge ref_clk) disable iff (rst)
        s_rr_req |=> $stable(carry_reg);
    endproperty
    a_rr_carry: assert property (p_rr_carry) else $error("right rotate moved carry");

    // A right rotate followed by an idle cycle: strobe falls, byte holds.
    // Guards against a write strobe that lingers and rewrites memory.
    property p_rr_then_idle;
        @(posedge ref_clk) disable iff (rst)
        s_rr_req ##1 s_idle |=> !mem_we_reg && $stable(result_reg);
    endproperty
    a_rr_then_idle: assert property (p_rr_then_idle) else $error("right rotate rewrote");

endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the rotate datapath top module.
// Assumes the rotate package and constants header are compiled first.
`timescale 1ns/1ps

module testbench;
    import rotate_pkg::*;

    logic           ref_clk;     // 50 MHz clock
    logic           rst;         // Async reset, active high
    logic           req_valid;   // Request strobe
    rot_req_t       req;         // Request fields
    logic [7:0]     result_reg;  // Rotated byte seen
    logic           mem_we_reg;  // Memory write strobe seen
    logic           acc_we_reg;  // Accumulator write strobe seen
    logic           carry_reg;   // Carry flag seen
    logic           done_reg;    // Done pulse seen
    int             err_total;   // Mismatches
    int             checks;      // Comparisons made
    int             cycles;      // Cycle count for the hang limit

    // Row: op, operand, carry in, value, carry after, mem strobe, acc strobe.
    // Carry after depends on earlier rows, so row order matters.
    logic [21:0]    rows [8] = '{
        {2'h0, 8'h81, 1'h1, 8'h03, 1'h0, 1'h0, 1'h1},
        {2'h1, 8'h80, 1'h1, 8'h01, 1'h1, 1'h1, 1'h0},
        {2'h3, 8'h01, 1'h0, 8'h80, 1'h1, 1'h1, 1'h0},
        {2'h0, 8'h7f, 1'h0, 8'hfe, 1'h1, 1'h0, 1'h1},
        {2'h2, 8'h7f, 1'h0, 8'hfe, 1'h0, 1'h0, 1'h1},
        {2'h3, 8'hfe, 1'h1, 8'h7f, 1'h0, 1'h1, 1'h0},
        {2'h2, 8'hc0, 1'h1, 8'h81, 1'h1, 1'h0, 1'h1},
        {2'h1, 8'h00, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0}};

    rotate_datapath uut (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .req_valid  (req_valid),
        .req        (req),
        .result_reg (result_reg),
        .mem_we_reg (mem_we_reg),
        .acc_we_reg (acc_we_reg),
        .carry_reg  (carry_reg),
        .done_reg   (done_reg)
    );

    // Free-running clock
    always #10 ref_clk = ~ref_clk;

    // Hang limit, far above the few dozen cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            test_done();
        end
    end

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // All outputs at once; keeps scenario code short
    task automatic check_out(input logic [7:0] v, input logic c, m, a, d);
        check_byte("result_reg", v, result_reg);
        check_bit("carry_reg", c, carry_reg);
        check_bit("mem_we_reg", m, mem_we_reg);
        check_bit("acc_we_reg", a, acc_we_reg);
        check_bit("done_reg", d, done_reg);
    endtask

    // Launch a request just after the edge
    task automatic send(input logic [1:0] op, input logic [7:0] b, input logic c);
        @(posedge ref_clk);
        #1;
        req_valid = 1'h1;
        req = '{op: rot_op_t'(op), operand: b, carry_in: c};
    endtask

    // Drop the strobe and scramble req so an ignored request would show
    task automatic idle();
        @(posedge ref_clk);
        #1;
        req_valid = 1'h0;
        req = rot_req_t'(~req);
    endtask

    task automatic test_done();
        $display("Comparisons %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: table, then back-to-back and reset in mid-run
    initial begin
        logic [1:0] op;
        logic [7:0] b;
        logic       c;
        logic [7:0] v;
        logic       cy;
        logic       m;
        logic       a;
        ref_clk = 1'h0;
        rst = 1'h1;
        req_valid = 1'h0;
        req = '0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'h0;
        check_out(8'h00, 1'h0, 1'h0, 1'h0, 1'h0);
        for (int i = 0; i < 8; i++) begin
            {op, b, c, v, cy, m, a} = rows[i];
            send(op, b, c);
            idle();
            check_out(v, cy, m, a, 1'h1);
            idle();
            check_out(v, cy, 1'h0, 1'h0, 1'h0);
        end
        send(2'h1, 8'h80, 1'h0);
        send(2'h0, 8'h01, 1'h1);
        check_out(8'h00, 1'h1, 1'h1, 1'h0, 1'h1);
        idle();
        check_out(8'h02, 1'h1, 1'h0, 1'h1, 1'h1);
        rst = 1'h1;
        #2;
        check_out(8'h00, 1'h0, 1'h0, 1'h0, 1'h0);
        idle();
        rst = 1'h0;
        send(2'h3, 8'h03, 1'h1);
        idle();
        check_out(8'h81, 1'h0, 1'h1, 1'h0, 1'h1);
        test_done();
    end
endmodule
